// ### rtl/light_sensor_user_registers.sv
// User register bank with critical error flag logic of the light sensor.
// Assumes the command decoder on mclk issues one-cycle register requests.
// What this block does
// - Wake pin falling edge in sleep sets error.
// - Clipped amplifier output sets critical error.
// - Other monitored nodes out of range set error.
// - Error source register records each failing node.
// - Flag follows any error source bit set.
// - Analog settings power up at 0x05.
// - Demodulator delay equals code times 0.4 us.
// - Gain bit selects LED driver high gain.
// - Lead-time codes give 50/100/200/400 us.
// - Bypass bit skips ADC buffer, active light only.
// - Critical error reported as status bit 0.
// - Writing ones to error source bits 1-6 is invalid.
`timescale 1ns/1ps
`default_nettype none

module light_sensor_user_registers
    import light_sensor_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire reg_req_type     req,
    input  wire logic            sleep_mode,
    input  wire logic            active_light_meas,
    input  wire logic            wake_trigger_pin,
    input  wire monitor_type     monitor,
    input  wire logic [1:0]      reset_cause_set,
    output logic [7:0]           rdata,
    output logic [7:0]           status_flags,
    output logic                 critical_error,
    output analog_ctrl_type      analog_ctrl,
    output logic [7:0]           channel_a_dac,
    output logic [7:0]           channel_a_filter,
    output logic [7:0]           channel_b_dac,
    output logic [7:0]           channel_b_filter,
    output logic [7:0]           pulse_train,
    output logic [7:0]           bandgap_trim,
    output logic [7:0]           temp_trim,
    output logic [7:0]           channel_enables,
    output logic [7:0]           ambient_select
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // The wake chain resets to the pin's idle high level, so release makes no false edge.
    logic [2:0] wake_sync_q;
    logic [5:0] mon_meta_q;
    logic [5:0] mon_sync_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wake_sync_q <= 3'h7;
            mon_meta_q  <= 6'h00;
            mon_sync_q  <= 6'h00;
        end else begin
            wake_sync_q <= {wake_sync_q[1:0], wake_trigger_pin};
            mon_meta_q  <= monitor;
            mon_sync_q  <= mon_meta_q;
        end
    end

    // Edge detection reads only the second and third stages.
    wire wake_fall = wake_sync_q[2] & ~wake_sync_q[1];

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] analog_q;
    logic [7:0] ch_a_dac_q;
    logic [7:0] ch_a_filt_q;
    logic [7:0] ch_b_dac_q;
    logic [7:0] ch_b_filt_q;
    logic [7:0] pulse_q;
    logic [7:0] err_q;
    logic [7:0] err_d;
    logic [7:0] rst_cause_q;
    logic [7:0] rst_cause_d;
    logic [7:0] gain_q;
    logic [7:0] bg_trim_q;
    logic [7:0] temp_trim_q;
    logic [7:0] chan_en_q;
    logic [7:0] amb_q;
    logic       invalid_q;

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    wire wr = req.wr;
    wire rd = req.rd;

    wire wr_analog  = wr && (req.addr == ANALOG_CHAIN_SETTINGS_OFS);
    wire wr_ch_a_d  = wr && (req.addr == CHANNEL_A_DAC_LEVEL_OFS);
    wire wr_ch_a_f  = wr && (req.addr == CHANNEL_A_FILTER_SETTINGS_OFS);
    wire wr_ch_b_d  = wr && (req.addr == CHANNEL_B_DAC_LEVEL_OFS);
    wire wr_ch_b_f  = wr && (req.addr == CHANNEL_B_FILTER_SETTINGS_OFS);
    wire wr_pulse   = wr && (req.addr == PULSE_TRAIN_SETTINGS_OFS);
    wire wr_err     = wr && (req.addr == CRITICAL_ERROR_SOURCES_OFS);
    wire wr_rst     = wr && (req.addr == RESET_CAUSE_FLAGS_OFS);
    wire wr_gain    = wr && (req.addr == ADC_BUFFER_GAIN_OFS);
    wire wr_bg      = wr && (req.addr == BANDGAP_TC_TRIM_OFS);
    wire wr_temp    = wr && (req.addr == TEMPERATURE_TRIM_OFS);
    wire wr_chan    = wr && (req.addr == CHANNEL_ENABLES_OFS);
    wire wr_amb     = wr && (req.addr == AMBIENT_TEMPERATURE_SELECT_OFS);

    // Writing a one into any error bit is an invalid command; nothing is cleared.
    wire err_write_bad = wr_err && ((req.wdata & ERROR_SOURCES_MASK) != 8'h00);
    wire cmd_seen      = wr | rd;

    // ----------------------------------------------------------------
    // Error sources
    // ----------------------------------------------------------------
    logic [7:0] err_set;

    // Clipping at either rail of the amplifier counts as one source.
    wire amp_clipped = mon_sync_q[5] | mon_sync_q[4];

    always_comb begin
        err_set = 8'h00;
        err_set[ERR_AMP_CLIP_BIT]    = amp_clipped;
        err_set[ERR_DAC_SHUNT_BIT]   = mon_sync_q[3];
        err_set[ERR_REFERENCE_BIT]   = mon_sync_q[2];
        err_set[ERR_COMMON_MODE_BIT] = mon_sync_q[1];
        err_set[ERR_OSCILLATOR_BIT]  = mon_sync_q[0];
        err_set[ERR_WAKE_BIT]        = wake_fall & sleep_mode;
    end

    // A valid write of all zeros clears; a new event in that cycle still sets.
    wire err_clear = wr_err && !err_write_bad;

    always_comb begin
        err_d = err_q;
        if (err_clear) begin
            err_d = 8'h00;
        end
        err_d = (err_d | err_set) & ERROR_SOURCES_MASK;
    end

    // Reset cause bits are set by hardware and cleared by writing one.
    always_comb begin
        rst_cause_d = rst_cause_q;
        if (wr_rst) begin
            rst_cause_d = rst_cause_q & ~req.wdata;
        end
        rst_cause_d = (rst_cause_d | {6'h00, reset_cause_set}) & RESET_CAUSE_MASK;
    end

    // ----------------------------------------------------------------
    // Register updates
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            analog_q <= ANALOG_CHAIN_SETTINGS_RST;
        end else if (wr_analog) begin
            analog_q <= req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ch_a_dac_q  <= ZERO_RST;
            ch_a_filt_q <= CHANNEL_FILTER_SETTINGS_RST;
            ch_b_dac_q  <= ZERO_RST;
            ch_b_filt_q <= CHANNEL_FILTER_SETTINGS_RST;
        end else begin
            if (wr_ch_a_d) ch_a_dac_q  <= req.wdata;
            if (wr_ch_a_f) ch_a_filt_q <= req.wdata;
            if (wr_ch_b_d) ch_b_dac_q  <= req.wdata;
            if (wr_ch_b_f) ch_b_filt_q <= req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pulse_q     <= ZERO_RST;
            gain_q      <= ZERO_RST;
            bg_trim_q   <= ZERO_RST;
            temp_trim_q <= ZERO_RST;
            chan_en_q   <= ZERO_RST;
            amb_q       <= ZERO_RST;
        end else begin
            if (wr_pulse) pulse_q     <= req.wdata & PULSE_TRAIN_MASK;
            if (wr_gain)  gain_q      <= req.wdata & ADC_BUFFER_GAIN_MASK;
            if (wr_bg)    bg_trim_q   <= req.wdata & BANDGAP_TC_TRIM_MASK;
            if (wr_temp)  temp_trim_q <= req.wdata & TEMPERATURE_TRIM_MASK;
            if (wr_chan)  chan_en_q   <= req.wdata & CHANNEL_ENABLES_MASK;
            if (wr_amb)   amb_q       <= req.wdata & AMBIENT_TEMPERATURE_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Error, reset cause and invalid command flags
    // ----------------------------------------------------------------
    // Error bits start clear; a node still out of range sets them again after reset.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            err_q       <= ZERO_RST;
            rst_cause_q <= ZERO_RST;
            invalid_q   <= 1'b0;
        end else begin
            err_q       <= err_d;
            rst_cause_q <= rst_cause_d;
            if (cmd_seen) begin
                invalid_q <= err_write_bad;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        case (req.addr)
            ANALOG_CHAIN_SETTINGS_OFS:      rd_mux = analog_q;
            CHANNEL_A_DAC_LEVEL_OFS:        rd_mux = ch_a_dac_q;
            CHANNEL_A_FILTER_SETTINGS_OFS:  rd_mux = ch_a_filt_q;
            CHANNEL_B_DAC_LEVEL_OFS:        rd_mux = ch_b_dac_q;
            CHANNEL_B_FILTER_SETTINGS_OFS:  rd_mux = ch_b_filt_q;
            PULSE_TRAIN_SETTINGS_OFS:       rd_mux = pulse_q;
            CRITICAL_ERROR_SOURCES_OFS:     rd_mux = err_q;
            RESET_CAUSE_FLAGS_OFS:          rd_mux = rst_cause_q;
            ADC_BUFFER_GAIN_OFS:            rd_mux = gain_q;
            BANDGAP_TC_TRIM_OFS:            rd_mux = bg_trim_q;
            TEMPERATURE_TRIM_OFS:           rd_mux = temp_trim_q;
            CHANNEL_ENABLES_OFS:            rd_mux = chan_en_q;
            AMBIENT_TEMPERATURE_SELECT_OFS: rd_mux = amb_q;
            default:                        rd_mux = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Decoded analog controls
    // ----------------------------------------------------------------
    wire [3:0]  demod_code   = analog_q[DEMOD_CODE_LSB +: 4];
    wire        led_high     = analog_q[LED_HIGH_GAIN_BIT];
    wire [1:0]  lead_code    = analog_q[DC_LEAD_LSB +: 2];
    wire        bypass_bit   = analog_q[BUFFER_BYPASS_BIT];

    // Counts are whole mclk cycles; the widths hold the largest code.
    wire [7:0]  demod_cycles = 8'(demod_code * DEMOD_STEP_CYCLES);
    wire [15:0] lead_cycles  = 16'(DC_LEAD_BASE_CYCLES << lead_code);
    wire        bypass_now   = bypass_bit & active_light_meas;

    analog_ctrl_type analog_d;

    always_comb begin
        analog_d.demod_delay_cycles   = demod_cycles;
        analog_d.led_driver_high_gain = led_high;
        analog_d.dc_lead_cycles       = lead_cycles;
        analog_d.adc_buffer_bypass    = bypass_now;
        analog_d.adc_gain             = gain_q[4:0];
    end

    // ----------------------------------------------------------------
    // Read data and status outputs
    // ----------------------------------------------------------------
    // The flag and status bit 0 follow the error register one cycle later.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata          <= 8'h00;
            status_flags   <= 8'h00;
            critical_error <= 1'b0;
        end else begin
            if (rd) rdata <= rd_mux;
            critical_error <= |err_q;
            status_flags   <= {invalid_q, 6'h00, |err_q};
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            analog_ctrl      <= '0;
            channel_a_dac    <= 8'h00;
            channel_a_filter <= 8'h00;
            channel_b_dac    <= 8'h00;
            channel_b_filter <= 8'h00;
            pulse_train      <= 8'h00;
            bandgap_trim     <= 8'h00;
            temp_trim        <= 8'h00;
            channel_enables  <= 8'h00;
            ambient_select   <= 8'h00;
        end else begin
            analog_ctrl      <= analog_d;
            channel_a_dac    <= ch_a_dac_q;
            channel_a_filter <= ch_a_filt_q;
            channel_b_dac    <= ch_b_dac_q;
            channel_b_filter <= ch_b_filt_q;
            pulse_train      <= pulse_q;
            bandgap_trim     <= bg_trim_q;
            temp_trim        <= temp_trim_q;
            channel_enables  <= chan_en_q;
            ambient_select   <= amb_q;
        end
    end

endmodule : light_sensor_user_registers

`default_nettype wire

// ### rtl/light_sensor_pkg.sv
// Package for the light sensor user register bank.
// Assumes a single 40 MHz clock domain and an internal register access port.
package light_sensor_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] ANALOG_CHAIN_SETTINGS_OFS      = 4'h0;
    localparam logic [3:0] CHANNEL_A_DAC_LEVEL_OFS        = 4'h1;
    localparam logic [3:0] CHANNEL_A_FILTER_SETTINGS_OFS  = 4'h2;
    localparam logic [3:0] CHANNEL_B_DAC_LEVEL_OFS        = 4'h3;
    localparam logic [3:0] CHANNEL_B_FILTER_SETTINGS_OFS  = 4'h4;
    localparam logic [3:0] PULSE_TRAIN_SETTINGS_OFS       = 4'h5;
    localparam logic [3:0] CRITICAL_ERROR_SOURCES_OFS     = 4'h6;
    localparam logic [3:0] RESET_CAUSE_FLAGS_OFS          = 4'h7;
    localparam logic [3:0] ADC_BUFFER_GAIN_OFS            = 4'hA;
    localparam logic [3:0] BANDGAP_TC_TRIM_OFS            = 4'hB;
    localparam logic [3:0] TEMPERATURE_TRIM_OFS           = 4'hC;
    localparam logic [3:0] CHANNEL_ENABLES_OFS            = 4'hD;
    localparam logic [3:0] AMBIENT_TEMPERATURE_SELECT_OFS = 4'hE;

    // ----------------------------------------------------------------
    // Reset values and writable-bit masks
    // ----------------------------------------------------------------
    localparam logic [7:0] ANALOG_CHAIN_SETTINGS_RST     = 8'h05;
    localparam logic [7:0] CHANNEL_FILTER_SETTINGS_RST   = 8'h0D;
    localparam logic [7:0] ZERO_RST                      = 8'h00;
    localparam logic [7:0] PULSE_TRAIN_MASK              = 8'hF7;
    localparam logic [7:0] ERROR_SOURCES_MASK            = 8'h7E;
    localparam logic [7:0] RESET_CAUSE_MASK              = 8'h03;
    localparam logic [7:0] ADC_BUFFER_GAIN_MASK          = 8'h1F;
    localparam logic [7:0] BANDGAP_TC_TRIM_MASK          = 8'hF8;
    localparam logic [7:0] TEMPERATURE_TRIM_MASK         = 8'h3F;
    localparam logic [7:0] CHANNEL_ENABLES_MASK          = 8'hFE;
    localparam logic [7:0] AMBIENT_TEMPERATURE_MASK      = 8'h03;

    // ----------------------------------------------------------------
    // Error source bit positions in critical_error_sources
    // ----------------------------------------------------------------
    localparam int ERR_AMP_CLIP_BIT   = 1;
    localparam int ERR_DAC_SHUNT_BIT  = 2;
    localparam int ERR_REFERENCE_BIT  = 3;
    localparam int ERR_COMMON_MODE_BIT = 4;
    localparam int ERR_OSCILLATOR_BIT = 5;
    localparam int ERR_WAKE_BIT       = 6;

    // ----------------------------------------------------------------
    // Field positions in analog_chain_settings
    // ----------------------------------------------------------------
    localparam int DEMOD_CODE_LSB      = 4;
    localparam int LED_HIGH_GAIN_BIT   = 3;
    localparam int DC_LEAD_LSB         = 1;
    localparam int BUFFER_BYPASS_BIT   = 0;

    // ----------------------------------------------------------------
    // Status byte bit positions
    // ----------------------------------------------------------------
    localparam int STATUS_CRIT_ERR_BIT = 0;
    localparam int STATUS_INVALID_BIT  = 7;

    // ----------------------------------------------------------------
    // Analog chain timing (ns, us) and derived 40 MHz cycle counts
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 25;
    localparam int DEMOD_STEP_NS       = 400;
    localparam int DEMOD_STEP_CYCLES   = DEMOD_STEP_NS / CLK_PERIOD_NS;
    localparam int DC_LEAD_BASE_US     = 50;
    localparam int DC_LEAD_BASE_CYCLES = (DC_LEAD_BASE_US * 1000) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic transimpedance_amplifier_clip_high;
        logic transimpedance_amplifier_clip_low;
        logic dac_shunt_oor;
        logic reference_oor;
        logic common_mode_oor;
        logic oscillator_oor;
    } monitor_type;

    typedef struct packed {
        logic [7:0]  demod_delay_cycles;
        logic        led_driver_high_gain;
        logic [15:0] dc_lead_cycles;
        logic        adc_buffer_bypass;
        logic [4:0]  adc_gain;
    } analog_ctrl_type;

endpackage : light_sensor_pkg

// ### dv/light_sensor_chk.sv
// Checker for the light sensor user register bank.
// Assumes it is bound to the register bank and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module light_sensor_chk
    import light_sensor_pkg::*;
(
    input wire logic            mclk,
    input wire logic            rst_n,
    input wire reg_req_type     req,
    input wire logic            sleep_mode,
    input wire logic            active_light_meas,
    input wire monitor_type     monitor,
    input wire logic [7:0]      status_flags,
    input wire logic            critical_error,
    input wire analog_ctrl_type analog_ctrl
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    wire err_wr = req.wr && (req.addr == CRITICAL_ERROR_SOURCES_OFS);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_flag_in_status: assert property (status_flags[0] == critical_error)
        else $error("status bit 0 differs from flag");
    a_clip_raises_flag: assert property ((monitor[5] || monitor[4]) [*6] |-> critical_error)
        else $error("clip did not raise flag");
    a_node_raises_flag: assert property ((|monitor[3:0]) [*6] |-> critical_error)
        else $error("node fault did not raise flag");
    a_flag_holds_high: assert property (critical_error && !$past(err_wr) |=> critical_error)
        else $error("flag dropped without clear");
    a_clear_drops_flag: assert property (err_wr && req.wdata == 8'h00 && !sleep_mode
        && !$past(sleep_mode) && !$past(sleep_mode, 2) && $past(monitor) == '0
        && $past(monitor, 2) == '0 |-> ##2 !critical_error)
        else $error("flag stayed after clear");
    a_bad_write_flagged: assert property (err_wr && req.wdata[6:1] != 6'h00
        |-> ##2 status_flags[7])
        else $error("invalid write not flagged");
    a_read_clears_bad: assert property (req.rd && req.addr == ANALOG_CHAIN_SETTINGS_OFS
        |-> ##2 !status_flags[7])
        else $error("valid read left invalid bit");
    a_demod_step: assert property (req.wr && req.addr == ANALOG_CHAIN_SETTINGS_OFS |-> ##2
        analog_ctrl.demod_delay_cycles == 8'($past(req.wdata[DEMOD_CODE_LSB +: 4], 2)
        * DEMOD_STEP_CYCLES))
        else $error("demod delay off for written code");
    a_lead_codes: assert property ($past(rst_n) && $past(rst_n, 2) |->
        analog_ctrl.dc_lead_cycles inside {16'h07D0, 16'h0FA0, 16'h1F40, 16'h3E80})
        else $error("dc lead count off");
    a_bypass_gated: assert property (!$past(active_light_meas)
        |-> !analog_ctrl.adc_buffer_bypass)
        else $error("bypass outside active light");
endmodule : light_sensor_chk

bind light_sensor_user_registers light_sensor_chk i_chk (
    .mclk(mclk), .rst_n(rst_n), .req(req), .sleep_mode(sleep_mode),
    .active_light_meas(active_light_meas), .monitor(monitor),
    .status_flags(status_flags), .critical_error(critical_error),
    .analog_ctrl(analog_ctrl)
);
`default_nettype wire

// ### dv/host_model.sv
// Host model that issues register commands to the register bank.
// Assumes requests change 1 ns after the rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import light_sensor_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [7:0]  rdata,
    output var  reg_req_type req
);
    initial req = '0;
    task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
        @(posedge mclk);
        #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge mclk);
        #1;
        req = '0;
    endtask : write_reg
    task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
        @(posedge mclk);
        #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge mclk);
        #1;
        req = '0;
        @(posedge mclk);
        #1;
        data = rdata;
    endtask : read_reg
    task automatic clear_errors();
        write_reg(CRITICAL_ERROR_SOURCES_OFS, 8'h00);
    endtask : clear_errors
endmodule : host_model
`default_nettype wire

// ### dv/test_light_sensor_user_registers.sv
// Self-checking bench for the light sensor user register bank.
// Assumes the host model, the bound checker and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_light_sensor_user_registers;
    import light_sensor_pkg::*;
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] w;
        logic [7:0] e;
    } row_type;
    logic            mclk = 1'b0;
    logic            rst_n = 1'b0;
    logic            sleep_mode = 1'b0;
    logic            alm = 1'b0;
    logic            wake = 1'b1;
    monitor_type     mon = '0;
    logic [1:0]      rcs = 2'h0;
    reg_req_type     req;
    logic [7:0]      rdata;
    logic [7:0]      status_flags;
    logic            critical_error;
    analog_ctrl_type analog_ctrl;
    logic [7:0]      pulse;
    logic [7:0]      amb;
    logic [7:0]      ca_d, ca_f, cb_d, cb_f, bg, tt, ce;
    logic [7:0]      d;
    logic [7:0]      v;
    int              miscompares = 0;
    int              tests_run = 0;
    row_type rows [14] = '{'{4'h0, 8'hFF, 8'hFF}, '{4'h1, 8'hFF, 8'hFF}, '{4'h2, 8'hA5, 8'hA5},
        '{4'h3, 8'hFF, 8'hFF}, '{4'h4, 8'h5A, 8'h5A}, '{4'h5, 8'hFF, 8'hF7},
        '{4'h8, 8'hFF, 8'h00}, '{4'h9, 8'hFF, 8'h00}, '{4'hA, 8'hFF, 8'h1F},
        '{4'hB, 8'hFF, 8'hF8}, '{4'hC, 8'hFF, 8'h3F}, '{4'hD, 8'hFF, 8'hFE},
        '{4'hE, 8'hFF, 8'h03}, '{4'hF, 8'hFF, 8'h00}};
    logic [7:0] err_exp [6] = '{8'h02, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
    always #12.5 mclk = ~mclk;
    host_model i_host (.mclk(mclk), .rdata(rdata), .req(req));
    light_sensor_user_registers i_dut (
        .mclk(mclk), .rst_n(rst_n), .req(req), .sleep_mode(sleep_mode),
        .active_light_meas(alm), .wake_trigger_pin(wake), .monitor(mon),
        .reset_cause_set(rcs), .rdata(rdata), .status_flags(status_flags),
        .critical_error(critical_error), .analog_ctrl(analog_ctrl),
        .channel_a_dac(ca_d), .channel_a_filter(ca_f), .channel_b_dac(cb_d),
        .channel_b_filter(cb_f), .pulse_train(pulse), .bandgap_trim(bg),
        .temp_trim(tt), .channel_enables(ce), .ambient_select(amb)
    );
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wait_flag(input logic lvl);
        for (int k = 0; k < 12 && critical_error !== lvl; k++) tick(1);
        chk(critical_error, lvl, "flag");
    endtask : wait_flag
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    initial begin
        #500000;
        miscompares++;
        end_sim();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        tick(5);
        rst_n = 1'b1;
        tick(2);
        chk(status_flags, 8'h00, "status");
        for (int a = 0; a < 16; a++) begin
            i_host.read_reg(a[3:0], d);
            chk(d, (a == 0) ? 8'h05 : (a == 2 || a == 4) ? 8'h0D : 8'h00, "init");
        end
        i_host.clear_errors();
        foreach (rows[r]) begin
            i_host.write_reg(rows[r].a, rows[r].w);
            i_host.read_reg(rows[r].a, d);
            chk(d, rows[r].e, "readback");
        end
        chk(pulse, 8'hF7, "pulse copy");
        chk(amb, 8'h03, "ambient copy");
        chk({ca_d, ca_f}, 16'hFFA5, "channel a copy");
        chk({cb_d, cb_f}, 16'hFF5A, "channel b copy");
        chk({bg, tt}, 16'hF83F, "trim copy");
        chk(ce, 8'hFE, "enable copy");
        chk(analog_ctrl.adc_gain, 5'h1F, "gain");
        for (int i = 0; i < 16; i++) begin
            v = {i[3:0], i[0], i[1:0], i[2]};
            alm = i[3];
            i_host.write_reg(ANALOG_CHAIN_SETTINGS_OFS, v);
            tick(1);
            chk(analog_ctrl.demod_delay_cycles, {i[3:0], 4'h0}, "demod");
            chk(analog_ctrl.led_driver_high_gain, v[3], "led gain");
            chk(analog_ctrl.dc_lead_cycles, 16'h07D0 << v[2:1], "lead");
            chk(analog_ctrl.adc_buffer_bypass, v[0] & alm, "bypass");
        end
        for (int j = 0; j < 6; j++) begin
            mon = monitor_type'(6'h20 >> j);
            wait_flag(1'b1);
            tick(3);
            mon = '0;
            tick(6);
            chk(critical_error, 1'b1, "held");
            chk(status_flags[0], 1'b1, "status");
            i_host.read_reg(CRITICAL_ERROR_SOURCES_OFS, d);
            chk(d, err_exp[j], "source");
            i_host.clear_errors();
            wait_flag(1'b0);
        end
        wake = 1'b0;
        tick(10);
        chk(critical_error, 1'b0, "awake");
        wake = 1'b1;
        sleep_mode = 1'b1;
        tick(6);
        wake = 1'b0;
        wait_flag(1'b1);
        i_host.read_reg(CRITICAL_ERROR_SOURCES_OFS, d);
        chk(d, 8'h40, "wake source");
        sleep_mode = 1'b0;
        wake = 1'b1;
        tick(6);
        i_host.clear_errors();
        wait_flag(1'b0);
        mon.reference_oor = 1'b1;
        mon.oscillator_oor = 1'b1;
        wait_flag(1'b1);
        mon = '0;
        tick(6);
        i_host.write_reg(CRITICAL_ERROR_SOURCES_OFS, 8'h02);
        tick(1);
        chk(status_flags[7], 1'b1, "invalid");
        i_host.read_reg(CRITICAL_ERROR_SOURCES_OFS, d);
        chk(d, 8'h28, "kept");
        chk(status_flags[7], 1'b0, "valid");
        i_host.clear_errors();
        wait_flag(1'b0);
        rcs = 2'h3;
        tick(1);
        rcs = 2'h0;
        i_host.read_reg(RESET_CAUSE_FLAGS_OFS, d);
        chk(d, 8'h03, "cause");
        i_host.write_reg(RESET_CAUSE_FLAGS_OFS, 8'hFF);
        i_host.read_reg(RESET_CAUSE_FLAGS_OFS, d);
        chk(d, 8'h00, "cause clear");
        rst_n = 1'b0;
        tick(5);
        rst_n = 1'b1;
        i_host.read_reg(ANALOG_CHAIN_SETTINGS_OFS, d);
        chk(d, 8'h05, "reinit");
        end_sim();
    end
endmodule : test_light_sensor_user_registers
`default_nettype wire
